// ---- src/rcwl_consts.vh ----
`ifndef RCWL_CONSTS_VH
`define RCWL_CONSTS_VH

// Flash configuration word addresses, 64 KB variant (program word address)
`define RCWL_CW1_ADDR 24'h00abfe
`define RCWL_CW2_ADDR 24'h00abfc
// Largest variant word 1 location
`define RCWL_CW1_ADDR_LARGE 24'h0157fe
// Configuration space window and base of the configuration bits
`define RCWL_CFG_SPACE_LO 24'h800000
`define RCWL_CFG_SPACE_HI 24'hffffff
`define RCWL_CFG_BASE 24'hf80000
// Unpacked configuration register count and stride (words of two addresses)
`define RCWL_CFG_REGS 5
`define RCWL_CFG_STRIDE 24'h000002
// Flash word layout: 24-bit word, upper byte unimplemented
`define RCWL_WORD_W 24
`define RCWL_CFG_BITS 16
// Erased (unprogrammed) value of configuration storage
`define RCWL_ERASED 16'hffff
// Flash read latency in cycles
`define RCWL_FLASH_LAT 4'h2

`endif

// ---- src/rcwl_cfg_reg.v ----
`timescale 1ns/100ps
`default_nettype none

// One volatile configuration register, loaded by the reset sequencer
module rcwl_cfg_reg #(
  parameter W = 16,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // Load and table write
  input wire i_load,
  input wire [W-1:0] i_load_data,
  input wire i_wr,
  input wire [W-1:0] i_wr_data,
  // Stored value
  output wire [W-1:0] o_value
);

  reg [W-1:0] value_ff;

  // Power-up content is the erased pattern; loader has priority over writes
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      value_ff <= INIT;
    end else if (i_load) begin
      value_ff <= i_load_data;
    end else if (i_wr) begin
      value_ff <= i_wr_data;
    end
  end

  assign o_value = value_ff;

endmodule // rcwl_cfg_reg

`default_nettype wire

// ---- src/rcwl_loader.v ----
// Contract
// - Configuration bit reads 0 when programmed, 1 when left unprogrammed.
// - Configuration bits map into program space starting at F80000h.
// - Configuration space 800000h-FFFFFFh reachable only by table reads and writes.
// - Configuration storage is volatile and reloaded after every power-up.
// - Source words sit at top of flash: 00ABFEh, 00ABFCh; largest 0157FEh.
// - Two packed flash words unpack into five configuration registers.
// - Flash words copy into configuration registers on every kind of reset.
// - Upper byte holds no configuration bits; ones written there do nothing.
`timescale 1ns/100ps
`default_nettype none
`include "rcwl_consts.vh"

module rcwl_loader #(
  parameter [23:0] CW1_ADDR = `RCWL_CW1_ADDR,
  parameter [23:0] CW2_ADDR = `RCWL_CW2_ADDR,
  parameter [3:0] FLASH_LAT = `RCWL_FLASH_LAT
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // Any device reset source (POR, BOR, WDT, MCLR, software)
  input wire i_dev_rst_req,
  // Flash read port
  output wire o_fl_rd,
  output wire [23:0] o_fl_addr,
  input wire [23:0] i_fl_data,
  // Table access port from the core
  input wire i_tbl_rd,
  input wire i_tbl_wr,
  input wire [23:0] i_tbl_addr,
  input wire [15:0] i_tbl_wdata,
  output wire [15:0] o_tbl_rdata,
  output wire o_tbl_err,
  // Ordinary fetch or data access address check
  input wire i_bus_acc,
  input wire [23:0] i_bus_addr,
  output wire o_bus_block,
  // Unpacked configuration and core reset
  output wire [79:0] o_cfg,
  output wire o_core_rst,
  output wire o_cfg_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD1 = 3'h1;
  localparam [2:0] ST_WT1 = 3'h2;
  localparam [2:0] ST_RD2 = 3'h3;
  localparam [2:0] ST_WT2 = 3'h4;
  localparam [2:0] ST_LOAD = 3'h5;
  localparam [2:0] ST_DONE = 3'h6;

  reg [2:0] state_ff, nxt_state;
  reg [3:0] lat_ff, nxt_lat;
  reg [15:0] w1_ff, nxt_w1;
  reg [15:0] w2_ff, nxt_w2;
  reg [23:0] addr_ff, nxt_addr;
  reg rd_ff, nxt_rd;
  reg core_rst_ff, nxt_core_rst;
  reg [15:0] tbl_rdata_ff, nxt_tbl_rdata;
  reg tbl_err_ff, nxt_tbl_err;

  ////////////////////////////////////////////////////////////////////////
  // Reset-time load sequence
  always @* begin
    nxt_state = state_ff;
    nxt_lat = lat_ff;
    nxt_w1 = w1_ff;
    nxt_w2 = w2_ff;
    nxt_addr = addr_ff;
    nxt_rd = 1'b0;
    nxt_core_rst = core_rst_ff;
    if (i_dev_rst_req) begin
      // Any reset restarts the copy, core held meanwhile
      nxt_state = ST_RD1;
      nxt_core_rst = 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_RD1; // Power-up reload of volatile storage
        end
        ST_RD1: begin
          nxt_addr = CW1_ADDR;
          nxt_rd = 1'b1;
          nxt_lat = FLASH_LAT;
          nxt_state = ST_WT1;
        end
        ST_WT1: begin
          if (lat_ff == 4'h0) begin
            nxt_w1 = i_fl_data[15:0]; // Upper byte dropped
            nxt_state = ST_RD2;
          end else begin
            nxt_lat = lat_ff - 4'h1;
          end
        end
        ST_RD2: begin
          nxt_addr = CW2_ADDR;
          nxt_rd = 1'b1;
          nxt_lat = FLASH_LAT;
          nxt_state = ST_WT2;
        end
        ST_WT2: begin
          if (lat_ff == 4'h0) begin
            nxt_w2 = i_fl_data[15:0];
            nxt_state = ST_LOAD;
          end else begin
            nxt_lat = lat_ff - 4'h1;
          end
        end
        ST_LOAD: begin
          nxt_state = ST_DONE;
        end
        ST_DONE: begin
          nxt_core_rst = 1'b0; // Release only after load
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // State, latency count and captured flash words
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      lat_ff <= 4'h0;
      w1_ff <= `RCWL_ERASED;
      w2_ff <= `RCWL_ERASED;
      addr_ff <= 24'h000000;
      rd_ff <= 1'b0;
      core_rst_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      lat_ff <= nxt_lat;
      w1_ff <= nxt_w1;
      w2_ff <= nxt_w2;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      core_rst_ff <= nxt_core_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unpacking into five configuration registers
  wire load = (state_ff == ST_LOAD);
  wire [79:0] packed_src;
  // Erased bits stay 1 (unprogrammed), programmed bits arrive as 0
  assign packed_src = {w2_ff[15:8], 8'hff, w2_ff[7:0], 8'hff, w1_ff[15:8], 8'hff,
                       w1_ff[7:0], 8'hff, 16'hffff};

  // Table address decode over the configuration bits region
  wire in_cfg_space = (i_tbl_addr >= `RCWL_CFG_SPACE_LO);
  wire [23:0] cfg_off = i_tbl_addr - `RCWL_CFG_BASE;
  wire cfg_hit = in_cfg_space && (i_tbl_addr >= `RCWL_CFG_BASE) &&
                 (cfg_off[23:1] < 23'h5) && !cfg_off[0];
  wire [2:0] cfg_idx = cfg_off[3:1];

  genvar g;
  generate
    for (g = 0; g < `RCWL_CFG_REGS; g = g + 1) begin : g_reg
      rcwl_cfg_reg #(
        .W(`RCWL_CFG_BITS),
        .INIT(`RCWL_ERASED)
      ) u_reg (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_load(load),
        .i_load_data(packed_src[g*16 +: 16]),
        .i_wr(i_tbl_wr && cfg_hit && (cfg_idx == g)),
        .i_wr_data(i_tbl_wdata),
        .o_value(o_cfg[g*16 +: 16])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Table read data and error flag
  always @* begin
    nxt_tbl_rdata = tbl_rdata_ff;
    nxt_tbl_err = 1'b0;
    if (i_tbl_rd || i_tbl_wr) begin
      if (cfg_hit) begin
        nxt_tbl_rdata = i_tbl_rd ? o_cfg[cfg_idx*16 +: 16] : tbl_rdata_ff;
      end else if (in_cfg_space) begin
        nxt_tbl_rdata = 16'h0000;
        nxt_tbl_err = i_tbl_wr;
      end
    end
  end

  // Read data holds between reads except that a read or write to unmapped configuration space clears it; error flag is a one-cycle pulse
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tbl_rdata_ff <= 16'h0000;
      tbl_err_ff <= 1'b0;
    end else begin
      tbl_rdata_ff <= nxt_tbl_rdata;
      tbl_err_ff <= nxt_tbl_err;
    end
  end

  // Non-table accesses into configuration space are blocked
  assign o_bus_block = i_bus_acc && (i_bus_addr >= `RCWL_CFG_SPACE_LO);

  // Outputs straight from flops; o_cfg_valid is decoded from state_ff
  assign o_fl_rd = rd_ff;
  assign o_fl_addr = addr_ff;
  assign o_tbl_rdata = tbl_rdata_ff;
  assign o_tbl_err = tbl_err_ff;
  assign o_core_rst = core_rst_ff;
  assign o_cfg_valid = (state_ff == ST_DONE);

endmodule // rcwl_loader

`default_nettype wire

// ---- dv/rcwl_loader_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rcwl_consts.vh"
module rcwl_loader_chk #(
  parameter [23:0] CW1_ADDR = `RCWL_CW1_ADDR,
  parameter [23:0] CW2_ADDR = `RCWL_CW2_ADDR
) (
  // Watched ports
  input wire i_ref_clk, input wire i_sys_rst, input wire i_dev_rst_req,
  input wire o_fl_rd, input wire [23:0] o_fl_addr,
  input wire i_tbl_rd, input wire i_tbl_wr, input wire [23:0] i_tbl_addr,
  input wire [15:0] o_tbl_rdata, input wire o_tbl_err,
  input wire i_bus_acc, input wire [23:0] i_bus_addr, input wire o_bus_block,
  input wire [79:0] o_cfg, input wire o_core_rst, input wire o_cfg_valid
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_BLK: assert property (o_bus_block == (i_bus_acc && i_bus_addr[23]))
    else $error("bus block wrong");
  AST_ADDR: assert property (o_fl_rd |-> o_fl_addr == CW1_ADDR || o_fl_addr == CW2_ADDR)
    else $error("flash address wrong");
  AST_ORDER: assert property (disable iff (i_sys_rst || i_dev_rst_req)
    o_fl_rd && o_fl_addr == CW1_ADDR |=> !o_fl_rd ##[1:9] o_fl_rd && o_fl_addr == CW2_ADDR)
    else $error("second word not read");
  AST_HOLD: assert property (!o_cfg_valid |-> o_core_rst)
    else $error("core released early");
  AST_RELOAD: assert property (i_dev_rst_req |-> ##[1:2] !o_cfg_valid)
    else $error("no reload on reset");
  AST_LOAD: assert property ($fell(i_sys_rst) |-> ##[4:30] o_cfg_valid)
    else $error("load not done");
  AST_FF: assert property ($rose(o_cfg_valid) |-> o_cfg[15:0] == 16'hffff &&
    o_cfg[23:16] == 8'hff && o_cfg[55:48] == 8'hff) else $error("fill bits wrong");
  AST_ERR: assert property (i_tbl_wr && i_tbl_addr[23] && i_tbl_addr[23:4] != 20'hf8000
    |=> o_tbl_err) else $error("no table error");
  AST_RD: assert property (i_tbl_rd && !i_tbl_wr && i_tbl_addr == 24'hf80002
    |=> o_tbl_rdata == $past(o_cfg[31:16])) else $error("table read wrong");
  // Main scenarios
  cover property ($rose(o_cfg_valid));
  cover property (o_tbl_err);
  cover property (o_bus_block);
endmodule // rcwl_loader_chk
bind rcwl_loader rcwl_loader_chk #(.CW1_ADDR(CW1_ADDR), .CW2_ADDR(CW2_ADDR)) i_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_dev_rst_req(i_dev_rst_req),
  .o_fl_rd(o_fl_rd), .o_fl_addr(o_fl_addr), .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr),
  .i_tbl_addr(i_tbl_addr), .o_tbl_rdata(o_tbl_rdata), .o_tbl_err(o_tbl_err),
  .i_bus_acc(i_bus_acc), .i_bus_addr(i_bus_addr), .o_bus_block(o_bus_block),
  .o_cfg(o_cfg), .o_core_rst(o_core_rst), .o_cfg_valid(o_cfg_valid));
`default_nettype wire

// ---- dv/rcwl_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rcwl_consts.vh"
module rcwl_flash_model #(
  parameter [23:0] CW1_ADDR = `RCWL_CW1_ADDR,
  parameter [23:0] CW2_ADDR = `RCWL_CW2_ADDR,
  parameter [3:0] LAT = `RCWL_FLASH_LAT
) (
  input wire i_ref_clk,
  input wire i_rd,
  input wire [23:0] i_addr,
  input wire [23:0] i_w1,
  input wire [23:0] i_w2,
  output var logic [23:0] o_data
);
  logic [3:0] age_ff = 4'hf;
  logic [23:0] word;
  // Reserved locations hold only configuration words
  always_comb word = (i_addr == CW1_ADDR) ? i_w1 : (i_addr == CW2_ADDR) ? i_w2 : 24'hffffff;
  // Cycles since the last read strobe
  always @(posedge i_ref_clk) age_ff <= i_rd ? 4'h0 : (age_ff == 4'hf ? age_ff : age_ff + 4'h1);
  // Data valid only in the read window, inverted outside it
  always_comb o_data = (age_ff <= LAT + 4'h1) ? word : ~word;
endmodule // rcwl_flash_model
`default_nettype wire

// ---- dv/tb_reset_config_word_loader.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_reset_config_word_loader;
  logic i_ref_clk = 0, i_sys_rst = 1, i_dev_rst_req = 0, i_tbl_rd = 0, i_tbl_wr = 0;
  logic i_bus_acc = 0, o_fl_rd, o_tbl_err, o_bus_block, o_core_rst, o_cfg_valid, tq_err;
  logic [23:0] i_tbl_addr = 0, i_bus_addr = 0, o_fl_addr, i_fl_data, w1, w2;
  logic [15:0] i_tbl_wdata = 0, o_tbl_rdata, d;
  logic [79:0] o_cfg, e;
  integer seed = 79711, num_errors = 0, compares = 0, g, n, it;
  rcwl_loader i_dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_dev_rst_req(i_dev_rst_req),
    .o_fl_rd(o_fl_rd), .o_fl_addr(o_fl_addr), .i_fl_data(i_fl_data),
    .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr), .i_tbl_addr(i_tbl_addr),
    .i_tbl_wdata(i_tbl_wdata), .o_tbl_rdata(o_tbl_rdata), .o_tbl_err(o_tbl_err),
    .i_bus_acc(i_bus_acc), .i_bus_addr(i_bus_addr), .o_bus_block(o_bus_block),
    .o_cfg(o_cfg), .o_core_rst(o_core_rst), .o_cfg_valid(o_cfg_valid));
  rcwl_flash_model i_flash (.i_ref_clk(i_ref_clk), .i_rd(o_fl_rd), .i_addr(o_fl_addr),
    .i_w1(w1), .i_w2(w2), .o_data(i_fl_data));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 i_ref_clk = ~i_ref_clk;
  task tick; @(posedge i_ref_clk); #1; endtask
  task chk(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected unpacked registers from the two flash words
  function automatic [79:0] exp_cfg(input [23:0] a, input [23:0] b);
    exp_cfg = {b[15:8], 8'hff, b[7:0], 8'hff, a[15:8], 8'hff, a[7:0], 8'hff, 16'hffff};
  endfunction
  task tbl(input logic wr, input [23:0] a, input [15:0] dt);
    i_tbl_wr = wr; i_tbl_rd = !wr; i_tbl_addr = a; i_tbl_wdata = dt;
    tick;
    tq_err = o_tbl_err; // Error flag stands for one cycle only
    i_tbl_wr = 0; i_tbl_rd = 0;
    tick;
  endtask
  task wait_load;
    n = 0;
    while (!(o_cfg_valid === 1'b1 && o_core_rst === 1'b0) && n < 100) begin tick; n++; end
    if (n >= 100) begin num_errors++; end_of_test; end
  endtask
  task new_words; // Upper byte always all ones
    w1 = {8'hff, 16'($random(seed))}; w2 = {8'hff, 16'($random(seed))};
  endtask
  task end_of_test;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    new_words;
    repeat (6) @(posedge i_ref_clk);
    #1 i_sys_rst = 0;
    for (it = 0; it < 4; it++) begin
      wait_load;
      e = exp_cfg(w1, w2);
      chk(o_cfg, e);
      for (g = 0; g < 5; g++) begin
        tbl(0, 24'hf80000 + 24'(2 * g), 16'h0000);
        chk(o_tbl_rdata, e[g*16+:16]);
      end
      d = 16'($random(seed));
      tbl(1, 24'hf80004, d);
      chk(o_cfg[47:32], d);
      chk(tq_err, 1'b0);
      tbl(1, 24'hf90000 | 24'({$random(seed)} % 4096), ~d);
      chk(tq_err, 1'b1);
      chk(o_cfg[47:32], d);
      i_bus_acc = 1;
      i_bus_addr = (it == 0) ? 24'h7fffff : (it == 1) ? 24'h800000 : 24'($random(seed));
      tick;
      chk(o_bus_block, i_bus_addr[23]);
      i_bus_acc = 0;
      new_words;
      i_dev_rst_req = 1;
      tick;
      i_dev_rst_req = 0;
      if (it == 1) begin // Power cycle in mid-load, volatile copy rebuilt
        i_sys_rst = 1;
        repeat (2) tick;
        i_sys_rst = 0;
      end
      if (it == 2) begin // Restart in mid-load with new words
        repeat (4) tick;
        new_words;
        i_dev_rst_req = 1;
        tick;
        i_dev_rst_req = 0;
      end
      tick;
    end
    end_of_test;
  end
endmodule // tb_reset_config_word_loader
`default_nettype wire
